// file: hw/amchl_map.vh
// Register offsets, field positions and reset values for the error block
`ifndef AMCHL_MAP_VH
`define AMCHL_MAP_VH

// Extended configuration byte offsets
`define AMCHL_OFF_COR_STATUS 12'h110
`define AMCHL_OFF_COR_MASK 12'h114
`define AMCHL_OFF_CAP_CTRL 12'h118
`define AMCHL_OFF_HDR_DW0 12'h11c
`define AMCHL_OFF_HDR_DW1 12'h120
`define AMCHL_OFF_HDR_DW2 12'h124
`define AMCHL_OFF_HDR_DW3 12'h128

// Correctable error bit positions (status and mask share them)
`define AMCHL_COR_RX_ERROR 0
`define AMCHL_COR_BAD_TLP 6
`define AMCHL_COR_BAD_DLLP 7
`define AMCHL_COR_REPLAY_ROLL 8
`define AMCHL_COR_REPLAY_EXPIRY 12
`define AMCHL_COR_ADVISORY 13

// Implemented correctable bits, split by which reset clears them
`define AMCHL_COR_IMPL 32'h000031c1
`define AMCHL_COR_FUND_ONLY 32'h000011c1
`define AMCHL_COR_ANY_RESET 32'h00002000

// Reset values
`define AMCHL_COR_MASK_RESET 32'h00002000
`define AMCHL_COR_STATUS_RESET 32'h00000000
`define AMCHL_CAP_CTRL_RESET 32'h000000a0
`define AMCHL_HDR_RESET 32'h00000000

// Capability and control field positions
`define AMCHL_CAP_CHECK_EN 8
`define AMCHL_CAP_CHECK_ABLE 7
`define AMCHL_CAP_GEN_EN 6
`define AMCHL_CAP_GEN_ABLE 5
`define AMCHL_CAP_PTR_MSB 4
`define AMCHL_CAP_PTR_LSB 0

`endif

// file: hw/amchl_hdr_mem.v
// Four-word header log store with registered read data
`timescale 1ns/1ps
module amchl_hdr_mem #(
    parameter DW = 32,
    parameter WORDS = 4,
    parameter AW = 2
) (
    // Clock and clear
    input wire clk,
    input wire clear,
    // Whole-header write
    input wire we,
    input wire [DW*WORDS-1:0] wdata,
    // Word read
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);

reg [DW-1:0] mem [0:WORDS-1];
integer i;

// Clear and capture all words at once; newest header overwrites older
always @(posedge clk)
begin
    if (clear)
    begin
        for (i = 0; i < WORDS; i = i + 1)
            mem[i] <= {DW{1'b0}};
    end
    else if (we)
    begin
        for (i = 0; i < WORDS; i = i + 1)
            mem[i] <= wdata[i*DW +: DW];
    end
end

// Read port registered; shows the old word on a write cycle
always @(posedge clk)
begin
    if (clear)
        rdata <= {DW{1'b0}};
    else
        rdata <= mem[raddr];
end

endmodule // amchl_hdr_mem

// file: hw/amchl_cor_status.v
// Correctable error status bits with mask gating and write-one-to-clear
`timescale 1ns/1ps
`include "amchl_map.vh"
module amchl_cor_status (
    // Clock and resets
    input wire clk,
    input wire reset,
    input wire fund_rst,
    // Error events and mask
    input wire [31:0] cor_err_event,
    input wire [31:0] cor_mask,
    // Software clear, one bit per status bit
    input wire [31:0] clear_bits,
    // Status and message request
    output reg [31:0] cor_status,
    output reg cor_msg_req
);

wire [31:0] hit;
reg [31:0] next_status;

// Masked errors never reach the status bits or the message
assign hit = cor_err_event & ~cor_mask & `AMCHL_COR_IMPL;

// A new event in the clear cycle survives the clear
always @*
begin
    next_status = (cor_status & ~clear_bits) | hit;
end

// Footnoted bits survive the ordinary reset
always @(posedge clk)
begin
    if (fund_rst)
    begin
        cor_status <= `AMCHL_COR_STATUS_RESET;
        cor_msg_req <= 1'b0;
    end
    else if (reset)
    begin
        cor_status <= cor_status & `AMCHL_COR_FUND_ONLY;
        cor_msg_req <= 1'b0;
    end
    else
    begin
        cor_status <= next_status;
        cor_msg_req <= |hit;
    end
end

endmodule // amchl_cor_status

// file: hw/amchl_regs.v
// Error mask, capability/control and header log registers
//
// Behaviour
// - Masked errors: no status, message, log, pointer
// - Correctable mask at 114h, resets 00002000h
// - Bit 13 advisory mask, default masked
// - Bits 12,8,7,6,0 masks, default unmasked
// - Mask reserved bits read as zero
// - Footnoted fields cleared only by fundamental reset
// - Control register at 118h, resets 000000a0h
// - Bit 8 enables end-to-end CRC checking
// - Bit 7 reads one: check ability
// - Bit 6 enables end-to-end CRC generation
// - Bit 5 reads one: generate ability
// - Bits 4:0 hold first error pointer
// - Offending header logged at 11Ch..128h
// - Earliest byte sits in lowest byte lane
// - Header log zero, cleared by fundamental reset
// - Status set by hardware, cleared writing one
`timescale 1ns/1ps
`include "amchl_map.vh"
module amchl_regs #(
    parameter HDR_WORDS = 4
) (
    // Clock and resets
    input wire clk,
    input wire reset,
    input wire pcie_reset_n,
    input wire global_reset_n,
    // Configuration access
    input wire [11:0] cfg_addr,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rd_valid,
    // Correctable error detection
    input wire [31:0] cor_err_event,
    // Uncorrectable error detection
    input wire uncor_err_valid,
    input wire [4:0] uncor_err_bit,
    input wire [31:0] uncor_mask,
    input wire [32*HDR_WORDS-1:0] err_hdr,
    input wire uncor_first_clear,
    // Control and status outputs
    output reg fundamental_reset_n,
    output reg e2e_crc_check_enable,
    output reg e2e_crc_generate_enable,
    output reg [31:0] correctable_error_mask,
    output wire [31:0] cor_status,
    output wire cor_msg_req,
    output reg hdr_logged
);

// Expand byte enables into a bit write mask
function [31:0] be_bits;
    input [3:0] be;
    begin
        be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
endfunction

// Wire order puts the first byte in bits 31:24; the log wants it low
function [31:0] wire_to_log;
    input [31:0] d;
    begin
        wire_to_log = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
endfunction

// Compare an address against a register offset
function hit_at;
    input [11:0] addr;
    input [11:0] off;
    begin
        hit_at = (addr[11:2] == off[11:2]);
    end
endfunction

wire fund_rst;
wire wr_mask;
wire wr_cap;
wire wr_status;
wire [31:0] wbits;
wire [31:0] mask_wr_bits;
wire [31:0] status_clear;
wire uncor_record;
wire hdr_sel;
wire [1:0] hdr_index;
wire [31:0] hdr_rdata;
wire [31:0] cap_ctrl_value;
wire [31:0] cap_reset;
reg [4:0] first_err_ptr;
reg first_err_valid;
reg [32*HDR_WORDS-1:0] hdr_log_data;
reg [31:0] next_mask;
reg [31:0] next_other;
reg rd_pending;
reg rd_hdr;
reg [31:0] rd_other;
integer k;

// Fundamental reset follows either reset pin, at the same edge
assign fund_rst = ~(pcie_reset_n & global_reset_n);

// Control reset word as a net, so single enable bits can be picked
assign cap_reset = `AMCHL_CAP_CTRL_RESET;

// Write strobes per register
assign wbits = be_bits(cfg_be);
assign wr_mask = cfg_wr & hit_at(cfg_addr, `AMCHL_OFF_COR_MASK);
assign wr_cap = cfg_wr & hit_at(cfg_addr, `AMCHL_OFF_CAP_CTRL);
assign wr_status = cfg_wr & hit_at(cfg_addr, `AMCHL_OFF_COR_STATUS);

// Only implemented mask bits take writes; reserved stay zero
assign mask_wr_bits = wbits & `AMCHL_COR_IMPL;
assign status_clear = wr_status ? (cfg_wdata & wbits) : 32'h00000000;

// Registered copy of the fundamental reset for outside logic
always @(posedge clk)
begin
    fundamental_reset_n <= pcie_reset_n & global_reset_n;
end

// Next mask value from a byte-enabled write
always @*
begin
    next_mask = correctable_error_mask;
    if (wr_mask)
    begin
        next_mask = (correctable_error_mask & ~mask_wr_bits)
            | (cfg_wdata & mask_wr_bits);
    end
end

// Mask register; advisory bit also obeys the ordinary reset
always @(posedge clk)
begin
    if (fund_rst)
    begin
        correctable_error_mask <= `AMCHL_COR_MASK_RESET;
    end
    else if (reset)
    begin
        correctable_error_mask <=
            (correctable_error_mask & `AMCHL_COR_FUND_ONLY)
            | (`AMCHL_COR_MASK_RESET & `AMCHL_COR_ANY_RESET);
    end
    else
    begin
        correctable_error_mask <= next_mask;
    end
end

// CRC enables; the ordinary reset leaves them alone
always @(posedge clk)
begin
    if (fund_rst)
    begin
        e2e_crc_check_enable <=
            cap_reset[`AMCHL_CAP_CHECK_EN];
        e2e_crc_generate_enable <=
            cap_reset[`AMCHL_CAP_GEN_EN];
    end
    else if (wr_cap)
    begin
        if (cfg_be[1])
            e2e_crc_check_enable <=
                cfg_wdata[`AMCHL_CAP_CHECK_EN];
        if (cfg_be[0])
            e2e_crc_generate_enable <=
                cfg_wdata[`AMCHL_CAP_GEN_EN];
    end
end

// An uncorrectable error counts only when its class is unmasked
assign uncor_record = uncor_err_valid
    & ~uncor_mask[uncor_err_bit];

// First error pointer holds until outside logic frees it;
// a new error in the freeing cycle takes the pointer at once
always @(posedge clk)
begin
    if (fund_rst)
    begin
        first_err_ptr <= 5'h00;
        first_err_valid <= 1'b0;
    end
    else if (uncor_record & (~first_err_valid | uncor_first_clear))
    begin
        first_err_ptr <= uncor_err_bit;
        first_err_valid <= 1'b1;
    end
    else if (uncor_first_clear)
    begin
        first_err_valid <= 1'b0;
    end
end

// Reorder each captured doubleword into log byte order
always @*
begin
    hdr_log_data = {32*HDR_WORDS{1'b0}};
    for (k = 0; k < HDR_WORDS; k = k + 1)
    begin
        hdr_log_data[k*32 +: 32] =
            wire_to_log(err_hdr[32*(HDR_WORDS-k)-1 -: 32]);
    end
end

// Header store; words 11Ch..128h map to index 0..3
assign hdr_sel = hit_at(cfg_addr, `AMCHL_OFF_HDR_DW0)
    | hit_at(cfg_addr, `AMCHL_OFF_HDR_DW1)
    | hit_at(cfg_addr, `AMCHL_OFF_HDR_DW2)
    | hit_at(cfg_addr, `AMCHL_OFF_HDR_DW3);
assign hdr_index = cfg_addr[3:2] + 2'h1;

amchl_hdr_mem #(
    .DW(32),
    .WORDS(HDR_WORDS),
    .AW(2)
) i_amchl_hdr_mem (
    .clk(clk),
    .clear(fund_rst),
    .we(uncor_record & ~fund_rst),
    .wdata(hdr_log_data),
    .raddr(hdr_index),
    .rdata(hdr_rdata)
);

// Pulse when a header is logged, for outside message logic
always @(posedge clk)
begin
    if (fund_rst | reset)
        hdr_logged <= 1'b0;
    else
        hdr_logged <= uncor_record;
end

// Correctable status bits
amchl_cor_status i_amchl_cor_status (
    .clk(clk),
    .reset(reset),
    .fund_rst(fund_rst),
    .cor_err_event(cor_err_event),
    .cor_mask(correctable_error_mask),
    .clear_bits(status_clear),
    .cor_status(cor_status),
    .cor_msg_req(cor_msg_req)
);

// Assembled control word; ability bits are constants
assign cap_ctrl_value = {23'h000000,
    e2e_crc_check_enable,
    1'b1,
    e2e_crc_generate_enable,
    1'b1,
    first_err_ptr};

// Read mux for the flop-held registers; unmapped reads give zero
always @*
begin
    next_other = 32'h00000000;
    if (hit_at(cfg_addr, `AMCHL_OFF_COR_STATUS))
        next_other = cor_status;
    else if (hit_at(cfg_addr, `AMCHL_OFF_COR_MASK))
        next_other = correctable_error_mask;
    else if (hit_at(cfg_addr, `AMCHL_OFF_CAP_CTRL))
        next_other = cap_ctrl_value;
end

// First read stage lines up with the registered log read
always @(posedge clk)
begin
    if (reset | fund_rst)
    begin
        rd_pending <= 1'b0;
        rd_hdr <= 1'b0;
        rd_other <= 32'h00000000;
    end
    else
    begin
        rd_pending <= cfg_rd;
        rd_hdr <= hdr_sel;
        rd_other <= next_other;
    end
end

// Second read stage drives the answer from a flop
always @(posedge clk)
begin
    if (reset | fund_rst)
    begin
        cfg_rdata <= 32'h00000000;
        cfg_rd_valid <= 1'b0;
    end
    else
    begin
        cfg_rd_valid <= rd_pending;
        if (rd_pending)
            cfg_rdata <= rd_hdr ? hdr_rdata : rd_other;
    end
end

endmodule // amchl_regs

// file: tb/amchl_regs_asserts.sv
// Port checker for the error mask, control and header log block
`timescale 1ns/1ps
module amchl_regs_asserts (
    // Clock and resets
    input wire clk,
    input wire reset,
    input wire pcie_reset_n,
    input wire global_reset_n,
    // Configuration access
    input wire [11:0] cfg_addr,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    input wire cfg_rd_valid,
    // Error inputs
    input wire [31:0] cor_err_event,
    input wire uncor_err_valid,
    input wire [4:0] uncor_err_bit,
    input wire [31:0] uncor_mask,
    // Observed outputs
    input wire fundamental_reset_n,
    input wire e2e_crc_check_enable,
    input wire e2e_crc_generate_enable,
    input wire [31:0] correctable_error_mask,
    input wire [31:0] cor_status,
    input wire cor_msg_req,
    input wire hdr_logged
);
    // Any reset kind restarts the pipelines, so checking pauses, except chk_fund_follow, which also runs during reset
    wire rst_any = reset | ~pcie_reset_n | ~global_reset_n;
    wire [31:0] live = cor_err_event & ~correctable_error_mask & 32'h000031c1;
    wire ctl_wr = cfg_wr && cfg_addr[11:2] == 10'h046;
    default clocking @(posedge clk); endclocking
    default disable iff (rst_any);
    sequence s_log;
        uncor_err_valid && !uncor_mask[uncor_err_bit];
    endsequence
    sequence s_ctl(lane);
        ctl_wr && cfg_be[lane];
    endsequence
    chk_read_latency: assert property (cfg_rd |-> ##2 cfg_rd_valid)
        else $error("read answer late");
    chk_valid_cause: assert property (cfg_rd_valid |-> $past(cfg_rd, 2))
        else $error("read answer without request");
    chk_mask_reserved: assert property ((correctable_error_mask & 32'hffffce3e) == 0)
        else $error("mask reserved bit set");
    chk_msg_cause: assert property (cor_msg_req |-> $past(|live))
        else $error("message without unmasked error");
    chk_msg_on_err: assert property (|live |=> cor_msg_req)
        else $error("unmasked error gave no message");
    chk_status_set: assert property (|live |=> (cor_status & $past(live)) == $past(live))
        else $error("status bit not set");
    chk_log_pulse: assert property (s_log |=> hdr_logged)
        else $error("header not logged");
    chk_log_cause: assert property (hdr_logged |-> $past(uncor_err_valid && !uncor_mask[uncor_err_bit]))
        else $error("header logged without error");
    chk_check_en: assert property (s_ctl(1) |=> e2e_crc_check_enable == $past(cfg_wdata[8]))
        else $error("check enable not written");
    chk_gen_en: assert property (s_ctl(0) |=> e2e_crc_generate_enable == $past(cfg_wdata[6]))
        else $error("generate enable not written");
    chk_fund_follow: assert property (disable iff (1'b0) !(pcie_reset_n && global_reset_n) |=> !fundamental_reset_n)
        else $error("fundamental reset missed a pin");
endmodule // amchl_regs_asserts

// file: tb/test_amchl_regs.sv
// Self-checking bench for the error mask, control and header log block
`timescale 1ns/1ps
module test_amchl_regs;
    reg clk = 0, reset = 1, pcie_reset_n = 0, global_reset_n = 1;
    reg cfg_wr = 0, cfg_rd = 0, uncor_err_valid = 0, uncor_first_clear = 0;
    reg [11:0] cfg_addr = 0;
    reg [3:0] cfg_be = 0;
    reg [31:0] cfg_wdata = 0, cor_err_event = 0, uncor_mask = 0;
    reg [4:0] uncor_err_bit = 0;
    reg [127:0] err_hdr = 128'h00112233_44556677_8899aabb_ccddeeff;
    wire [31:0] cfg_rdata, correctable_error_mask, cor_status;
    wire cfg_rd_valid, fundamental_reset_n, e2e_crc_check_enable;
    wire e2e_crc_generate_enable, cor_msg_req, hdr_logged;
    integer fail_count = 0, cmp_count = 0, k;
    amchl_regs i_amchl_regs (.clk, .reset, .pcie_reset_n, .global_reset_n,
        .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata,
        .cfg_rd_valid, .cor_err_event, .uncor_err_valid, .uncor_err_bit,
        .uncor_mask, .err_hdr, .uncor_first_clear, .fundamental_reset_n,
        .e2e_crc_check_enable, .e2e_crc_generate_enable,
        .correctable_error_mask, .cor_status, .cor_msg_req, .hdr_logged);
    // Clock at 40 MHz
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task summarize;
    begin
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task check(input string what, input [31:0] exp, input [31:0] got);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    end
    endtask
    // Inputs move on falling edges, away from the sampling edge
    task wr(input [11:0] a, input [3:0] be, input [31:0] d);
    begin
        @(negedge clk);
        {cfg_addr, cfg_be, cfg_wdata, cfg_wr} = {a, be, d, 1'b1};
        @(negedge clk);
        cfg_wr = 0;
    end
    endtask
    task rd(input [11:0] a, input [31:0] exp);
        integer n;
    begin
        @(negedge clk);
        {cfg_addr, cfg_rd} = {a, 1'b1};
        @(negedge clk);
        cfg_rd = 0;
        for (n = 0; n < 4 && cfg_rd_valid !== 1'b1; n = n + 1)
            @(negedge clk);
        if (n == 4)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] read valid exp 1 got 0");
            summarize;
        end
        else
            check($sformatf("reg %h", a), exp, cfg_rdata);
    end
    endtask
    task cor_pulse(input [31:0] ev, input exp);
    begin
        @(negedge clk);
        cor_err_event = ev;
        @(negedge clk);
        cor_err_event = 0;
        check("msg", exp, cor_msg_req);
    end
    endtask
    task unc_pulse(input [4:0] b, input exp);
    begin
        @(negedge clk);
        {uncor_err_bit, uncor_err_valid} = {b, 1'b1};
        @(negedge clk);
        uncor_err_valid = 0;
        check("logged", exp, hdr_logged);
    end
    endtask
    task t_defaults;
    begin
        rd(12'h114, 32'h00002000);
        rd(12'h118, 32'h000000a0);
        for (k = 0; k < 4; k = k + 1)
            rd(12'h11c + 4 * k, 0);
        rd(12'h100, 0);
        $display("t_defaults done");
    end
    endtask
    task t_fields;
    begin
        wr(12'h114, 4'hf, 32'hffffffff);
        rd(12'h114, 32'h000031c1);
        check("mask port", 32'h31c1, correctable_error_mask);
        wr(12'h114, 4'h2, 0);
        rd(12'h114, 32'h000000c1);
        wr(12'h118, 4'hf, 32'hffffffff);
        rd(12'h118, 32'h000001e0);
        check("enables", 2'b11, {e2e_crc_check_enable, e2e_crc_generate_enable});
        wr(12'h118, 4'hf, 0);
        rd(12'h118, 32'h000000a0);
        wr(12'h11c, 4'hf, 32'hffffffff);
        rd(12'h11c, 0);
        $display("t_fields done");
    end
    endtask
    task t_cor;
    begin
        wr(12'h114, 4'hf, 0);
        cor_pulse(32'h000031c1, 1);
        rd(12'h110, 32'h000031c1);
        wr(12'h110, 4'h1, 32'hffffffff);
        wr(12'h110, 4'hf, 0);
        rd(12'h110, 32'h00003100);
        wr(12'h114, 4'hf, 32'h000031c1);
        cor_pulse(32'h000031c1, 0);
        wr(12'h110, 4'hf, 32'hffffffff);
        cor_pulse(32'h000031c1, 0);
        rd(12'h110, 0);
        $display("t_cor done");
    end
    endtask
    task t_hdr;
    begin
        uncor_mask = 32'h00000020;
        unc_pulse(4, 1);
        rd(12'h11c, 32'h33221100);
        rd(12'h128, 32'hffeeddcc);
        rd(12'h118, 32'h000000a4);
        err_hdr = ~err_hdr;
        unc_pulse(5, 0);
        rd(12'h11c, 32'h33221100);
        unc_pulse(9, 1);
        rd(12'h118, 32'h000000a4);
        rd(12'h11c, 32'hccddeeff);
        @(negedge clk) uncor_first_clear = 1;
        @(negedge clk) uncor_first_clear = 0;
        unc_pulse(9, 1);
        rd(12'h118, 32'h000000a9);
        $display("t_hdr done");
    end
    endtask
    task t_resets;
    begin
        wr(12'h114, 4'hf, 32'h000011c1);
        wr(12'h118, 4'hf, 32'h00000100);
        @(negedge clk) reset = 1;
        @(negedge clk) reset = 0;
        rd(12'h114, 32'h000031c1);
        rd(12'h118, 32'h000001a9);
        rd(12'h11c, 32'hccddeeff);
        for (k = 0; k < 2; k = k + 1)
        begin
            wr(12'h114, 4'hf, 32'h000011c1);
            @(negedge clk) {pcie_reset_n, global_reset_n} = k ? 2'b10 : 2'b01;
            @(negedge clk) check("fund reset", 0, fundamental_reset_n);
            {pcie_reset_n, global_reset_n} = 2'b11;
            rd(12'h114, 32'h00002000);
            rd(12'h118, 32'h000000a0);
            rd(12'h11c, 0);
        end
        $display("t_resets done");
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(negedge clk);
        {reset, pcie_reset_n} = 2'b01;
        t_defaults;
        t_fields;
        t_cor;
        t_hdr;
        t_resets;
        summarize;
    end
endmodule // test_amchl_regs
bind amchl_regs amchl_regs_asserts i_amchl_regs_asserts (.clk, .reset,
    .pcie_reset_n, .global_reset_n, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
    .cfg_wdata, .cfg_rd_valid, .cor_err_event, .uncor_err_valid,
    .uncor_err_bit, .uncor_mask, .fundamental_reset_n,
    .e2e_crc_check_enable, .e2e_crc_generate_enable,
    .correctable_error_mask, .cor_status, .cor_msg_req, .hdr_logged);
